// ### logic/snv_pkg.sv
// Shared constants and types for the serial nonvolatile SRAM link
// Function
// - Write-inhibit high rejects writes, counter kept
// - Supply loss blocks access, saves if needed
// - Skip power-loss save when nothing written
// - Store pin pulled low requests delayed save
// - Refuse memory during save or pin low
// - Drive store pin low while saving
// - After requested save drive pin high briefly, release
// - Master requests save one clock after byte
// - Lock out memory after pin returns high
// - Power-up restore copies storage, blocks memory
// - Address lsb gives direction; write runs on
// - Unknown device identifier gets not-acknowledge
// - Protected write nacked, counter stays there
// - Nonexistent address nacked, counter kept
// - Read-only control location nacked, counter held
// - After nack ignore data until stop/start
// - Byte committed at eighth bit
// - Read drives data from the counter location, wraps
// - Control read past end wraps to zero
// - Master ends read with nack then stop
// - Memory counter increments, wraps to zero
// - Acknowledge memory byte after write completes
// - Protect level selects protected range
package snv_pkg;
  localparam longint unsigned CLK_MHZ = 125;
  localparam logic [6:0] MEM_DEV_ID = 7'h50; // Arbitrary value
  localparam logic [6:0] CTL_DEV_ID = 7'h18; // Arbitrary value
  localparam logic [7:0] DEVICE_ID_BYTE = 8'h5a; // Arbitrary value
  localparam int MEM_WORDS = 32768;
  localparam logic [14:0] MEM_LAST = 15'h7fff;
  localparam logic [15:0] MEM_TOP = 16'h8000;
  localparam logic [14:0] PROT_QTR_BASE = 15'h6000;
  localparam logic [14:0] PROT_HALF_BASE = 15'h4000;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QTR = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [7:0] CR_MEMCTL = 8'h00;
  localparam logic [7:0] CR_SER_LAST = 8'h08;
  localparam logic [7:0] CR_LAST = 8'h0c;
  localparam logic [7:0] CR_CMD = 8'haa;
  localparam int SNL_POS = 6;
  localparam int BP_LSB = 2;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Interval lengths in nanoseconds
  localparam longint unsigned SAVE_REQ_DELAY_NS = 500;
  localparam longint unsigned SAVE_DURATION_NS = 8000000;
  localparam longint unsigned BUSY_RELEASE_DRIVE_NS = 40;
  localparam longint unsigned POST_SAVE_LOCKOUT_NS = 200;
  localparam longint unsigned POWERUP_RESTORE_NS = 20000000;
  // Rounds a least time up to whole clock cycles
  function automatic int unsigned snv_cyc(input longint unsigned ns);
    longint unsigned c;
    c = (ns * CLK_MHZ + 64'd999) / 64'd1000;
    if (c == 0)
    begin
      c = 1;
    end
    return 32'(c);
  endfunction
  localparam int unsigned SAVE_REQ_DELAY_CYC = snv_cyc(SAVE_REQ_DELAY_NS);
  localparam int unsigned SAVE_DURATION_CYC = snv_cyc(SAVE_DURATION_NS);
  localparam int unsigned BUSY_RELEASE_CYC = snv_cyc(BUSY_RELEASE_DRIVE_NS);
  localparam int unsigned POST_LOCKOUT_CYC = snv_cyc(POST_SAVE_LOCKOUT_NS);
  localparam int unsigned RESTORE_CYC = snv_cyc(POWERUP_RESTORE_NS);
  localparam logic [3:0] SCL_QTR_CYC = 4'h4;
  localparam logic [7:0] STORE_REQ_HOLD_CYC = 8'h08;
  typedef enum logic [2:0] {S_IDLE, S_DEVSEL, S_ADDR_HI, S_ADDR_LO, S_WDATA,
    S_RDATA, S_IGNORE} snv_bus_st_t;
  typedef enum logic [2:0] {P_OFF, P_RESTORE, P_READY, P_REQ, P_SAVE,
    P_RELEASE, P_LOCK} snv_pwr_st_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_SAVE} snv_host_st_t;
endpackage

// ### logic/snv_if.sv
// Two-wire link and store pin joining host and device
`timescale 1ns/1ps
interface snv_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_st_o;
  logic host_st_oe_n;
  logic dev_st_o;
  logic dev_st_oe_n;
  logic sda;
  logic store_busy_pin;
  // Open-drain data line with pull-up
  assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
  // Store pin: any low driver wins, else driven high or pulled up
  assign store_busy_pin = ~((~host_st_oe_n & ~host_st_o) | (~dev_st_oe_n & ~dev_st_o));
  modport dev_mp (input scl, input sda, input store_busy_pin,
    output dev_sda_o, output dev_sda_oe_n, output dev_st_o, output dev_st_oe_n);
  modport host_mp (input sda, input store_busy_pin, output scl,
    output host_sda_o, output host_sda_oe_n, output host_st_o, output host_st_oe_n);
endinterface

// ### logic/snv_host.sv
// Bus master end: single transfers and hardware save requests
`timescale 1ns/1ps
module snv_host
  import snv_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link
  snv_if.host_mp bus,
  // Command
  input wire logic cmd_valid,
  input wire logic [6:0] cmd_dev,
  input wire logic cmd_rd,
  input wire logic [1:0] cmd_naddr,
  input wire logic [15:0] cmd_addr,
  input wire logic cmd_wr_en,
  input wire logic [7:0] cmd_wdata,
  input wire logic save_req,
  // Result
  output logic busy_q,
  output logic done_q,
  output logic nack_q,
  output logic [7:0] rd_data_q
);
  import snv_pkg::*;
  snv_host_st_t st_q;
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [3:0] qc_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [1:0] idx_q;
  logic [7:0] rx_q;
  logic [7:0] hold_q;
  logic [6:0] dev_q;
  logic rd_q;
  logic wr_en_q;
  logic [1:0] naddr_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic scl_q;
  logic sda_oe_n_q;
  logic st_oe_n_q;
  logic tick;
  logic rdbyte;
  logic lastbyte;
  logic [7:0] txb;
  logic [1:0] k;

  // Pin synchroniser for data line and store pin
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
    end
    else
    begin
      s1_q <= {bus.store_busy_pin, bus.sda};
      s2_q <= s1_q;
    end
  end

  // Byte to send for the current index
  always_comb
  begin
    k = idx_q - 2'h1;
    tick = (qc_q == SCL_QTR_CYC - 4'h1);
    rdbyte = rd_q && (idx_q != 2'h0);
    lastbyte = rd_q ? (idx_q == 2'h1) : (idx_q == naddr_q + {1'b0, wr_en_q});
    if (idx_q == 2'h0)
    begin
      txb = {dev_q, rd_q};
    end
    else if (k < naddr_q)
    begin
      txb = (naddr_q == 2'h2 && k == 2'h0) ? addr_q[15:8] : addr_q[7:0];
    end
    else
    begin
      txb = wdata_q;
    end
  end

  // Transfer sequencer on quarter-period ticks
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= H_IDLE;
      qc_q <= 4'h0;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      idx_q <= 2'h0;
      rx_q <= 8'h00;
      hold_q <= 8'h00;
      dev_q <= 7'h00;
      rd_q <= 1'b0;
      wr_en_q <= 1'b0;
      naddr_q <= 2'h0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      scl_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      st_oe_n_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rd_data_q <= 8'h00;
    end
    else
    begin
      done_q <= 1'b0;
      qc_q <= (st_q == H_IDLE || tick) ? 4'h0 : qc_q + 4'h1;
      case (st_q)
        H_IDLE:
        begin
          ph_q <= 2'h0;
          if (save_req)
          begin
            st_q <= H_SAVE;
            st_oe_n_q <= 1'b0;
            hold_q <= 8'h00;
            busy_q <= 1'b1;
          end
          else if (cmd_valid)
          begin
            st_q <= H_START;
            dev_q <= cmd_dev;
            rd_q <= cmd_rd;
            wr_en_q <= cmd_wr_en;
            naddr_q <= cmd_naddr;
            addr_q <= cmd_addr;
            wdata_q <= cmd_wdata;
            idx_q <= 2'h0;
            bit_q <= 4'h0;
            busy_q <= 1'b1;
            nack_q <= 1'b0;
          end
        end
        H_SAVE:
        begin
          hold_q <= hold_q + 8'h01;
          if (hold_q == STORE_REQ_HOLD_CYC - 8'h01)
          begin
            st_oe_n_q <= 1'b1;
            st_q <= H_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        H_START:
        begin
          if (tick)
          begin
            if (ph_q == 2'h0)
            begin
              sda_oe_n_q <= 1'b0;
              ph_q <= 2'h1;
            end
            else
            begin
              scl_q <= 1'b0;
              ph_q <= 2'h0;
              st_q <= H_BIT;
            end
          end
        end
        H_BIT:
        begin
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0)
            begin
              // Read bytes release the line; last read ack is a nack
              sda_oe_n_q <= rdbyte || bit_q == BIT_ACK || txb[3'(BIT_LAST - bit_q)];
            end
            else if (ph_q == 2'h1)
            begin
              scl_q <= 1'b1;
            end
            else if (ph_q == 2'h2)
            begin
              if (bit_q != BIT_ACK)
              begin
                rx_q <= {rx_q[6:0], s2_q[0]};
              end
              else if (!rdbyte && s2_q[0])
              begin
                nack_q <= 1'b1;
              end
            end
            else
            begin
              scl_q <= 1'b0;
              bit_q <= (bit_q == BIT_ACK) ? 4'h0 : bit_q + 4'h1;
              if (bit_q == BIT_ACK)
              begin
                if (rdbyte)
                begin
                  rd_data_q <= rx_q;
                end
                if (lastbyte || nack_q)
                begin
                  st_q <= H_STOP;
                end
                idx_q <= idx_q + 2'h1;
              end
            end
          end
        end
        default:
        begin
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0)
            begin
              sda_oe_n_q <= 1'b0;
            end
            else if (ph_q == 2'h1)
            begin
              scl_q <= 1'b1;
            end
            else if (ph_q == 2'h2)
            begin
              sda_oe_n_q <= 1'b1;
            end
            else
            begin
              st_q <= H_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Pin drivers
  assign bus.scl = scl_q;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe_n = sda_oe_n_q;
  assign bus.host_st_o = 1'b0;
  assign bus.host_st_oe_n = st_oe_n_q;
endmodule

// ### logic/snv_dev.sv
// Device end: serial slave, protection, save and restore control
`timescale 1ns/1ps
module snv_dev
  import snv_pkg::*;
#(
  parameter int unsigned SAVE_REQ_DELAY = SAVE_REQ_DELAY_CYC,
  parameter int unsigned SAVE_DURATION = SAVE_DURATION_CYC,
  parameter int unsigned RELEASE_DRIVE = BUSY_RELEASE_CYC,
  parameter int unsigned POST_LOCKOUT = POST_LOCKOUT_CYC,
  parameter int unsigned RESTORE_TIME = RESTORE_CYC
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link
  snv_if.dev_mp bus,
  // Device pins
  input wire logic supply_ok,
  input wire logic write_inhibit,
  // Status
  output logic mem_ready_q,
  output logic save_busy_q
);
  import snv_pkg::*;
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [1:0] prev_q;
  logic scl_s;
  logic sda_s;
  logic stb_s;
  logic wi_s;
  logic sup_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  snv_bus_st_t st_q;
  snv_bus_st_t nst_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic ack_q;
  logic load_q;
  logic sel_mem_q;
  logic [7:0] ahi_q;
  logic [14:0] mptr_q;
  logic [7:0] cptr_q;
  logic snl_q;
  logic [1:0] bp_q;
  logic [7:0] ser_q [0:7];
  logic sda_oe_n_q;
  logic mw_q;
  logic [14:0] mwa_q;
  logic [7:0] mwd_q;
  logic [7:0] mem_q [0:MEM_WORDS-1];
  logic [7:0] nv_q [0:MEM_WORDS-1];
  snv_pwr_st_t pst_q;
  logic [31:0] tim_q;
  logic [14:0] cp_q;
  logic cpd_q;
  logic pl_q;
  logic dirty_q;
  logic st_o_q;
  logic st_oe_n_q;
  logic [7:0] b;
  logic prot;
  logic [15:0] full_addr;
  logic [7:0] ca;
  logic [7:0] creg;

  // Two-flop synchroniser for every pin input
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= 5'h07;
      s2_q <= 5'h07;
      prev_q <= 2'h3;
    end
    else
    begin
      s1_q <= {supply_ok, write_inhibit, bus.store_busy_pin, bus.sda, bus.scl};
      s2_q <= s1_q;
      prev_q <= s2_q[1:0];
    end
  end

  // Line events and decoded byte
  always_comb
  begin
    {sup_s, wi_s, stb_s, sda_s, scl_s} = s2_q;
    scl_rise = scl_s && !prev_q[0];
    scl_fall = !scl_s && prev_q[0];
    start_ev = scl_s && prev_q[0] && !sda_s && prev_q[1];
    stop_ev = scl_s && prev_q[0] && sda_s && !prev_q[1];
    b = {sh_q[6:0], sda_s};
    full_addr = {ahi_q, b};
    // Protected range from the protect level field
    case (bp_q)
      BP_NONE: prot = 1'b0;
      BP_QTR: prot = mptr_q >= PROT_QTR_BASE;
      BP_HALF: prot = mptr_q >= PROT_HALF_BASE;
      default: prot = 1'b1;
    endcase
    // Reads past the last control location start over at zero
    ca = (cptr_q <= CR_LAST) ? cptr_q : CR_MEMCTL;
    if (ca == CR_MEMCTL)
    begin
      creg = 8'h00;
      creg[SNL_POS] = snl_q;
      creg[BP_LSB+:2] = bp_q;
    end
    else if (ca <= CR_SER_LAST)
    begin
      creg = ser_q[3'(ca - 8'h01)];
    end
    else
    begin
      creg = DEVICE_ID_BYTE;
    end
  end

  // Serial slave engine
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= S_IDLE;
      nst_q <= S_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ack_q <= 1'b0;
      load_q <= 1'b0;
      sel_mem_q <= 1'b0;
      ahi_q <= 8'h00;
      mptr_q <= 15'h0000;
      cptr_q <= 8'h00;
      snl_q <= 1'b0;
      bp_q <= BP_NONE;
      ser_q <= '{default: 8'h00};
      sda_oe_n_q <= 1'b1;
      mw_q <= 1'b0;
      mwa_q <= 15'h0000;
      mwd_q <= 8'h00;
    end
    else
    begin
      mw_q <= 1'b0;
      if (start_ev)
      begin
        st_q <= S_DEVSEL;
        bit_q <= 4'h0;
        load_q <= 1'b0;
        sda_oe_n_q <= 1'b1;
      end
      else if (stop_ev)
      begin
        st_q <= S_IDLE;
        sda_oe_n_q <= 1'b1;
      end
      else if (st_q == S_IDLE || st_q == S_IGNORE)
      begin
        sda_oe_n_q <= 1'b1;
      end
      else if (scl_rise && bit_q == BIT_ACK)
      begin
        bit_q <= 4'h0;
        load_q <= 1'b1;
        if (st_q == S_RDATA)
        begin
          st_q <= sda_s ? S_IGNORE : S_RDATA;
        end
        else
        begin
          st_q <= ack_q ? nst_q : S_IGNORE;
        end
      end
      else if (scl_rise)
      begin
        sh_q <= b;
        bit_q <= bit_q + 4'h1;
        if (bit_q == BIT_LAST && st_q != S_RDATA)
        begin
          ack_q <= 1'b1;
          nst_q <= st_q;
          case (st_q)
            S_DEVSEL:
            begin
              sel_mem_q <= b[7:1] == MEM_DEV_ID;
              // Memory needs a ready device; control needs supply
              ack_q <= (b[7:1] == MEM_DEV_ID && pst_q == P_READY) ||
                (b[7:1] == CTL_DEV_ID && pst_q != P_OFF && !pl_q);
              nst_q <= b[0] ? S_RDATA : (b[7:1] == MEM_DEV_ID ? S_ADDR_HI : S_ADDR_LO);
            end
            S_ADDR_HI:
            begin
              ahi_q <= b;
              nst_q <= S_ADDR_LO;
            end
            S_ADDR_LO:
            begin
              nst_q <= S_WDATA;
              if (sel_mem_q ? full_addr >= MEM_TOP : (b > CR_LAST && b != CR_CMD))
              begin
                ack_q <= 1'b0;
              end
              else if (sel_mem_q)
              begin
                mptr_q <= full_addr[14:0];
              end
              else
              begin
                cptr_q <= b;
              end
            end
            default:
            begin
              if (wi_s)
              begin
                ack_q <= 1'b0;
              end
              else if (sel_mem_q)
              begin
                if (prot)
                begin
                  ack_q <= 1'b0;
                end
                else
                begin
                  mw_q <= 1'b1;
                  mwa_q <= mptr_q;
                  mwd_q <= b;
                  mptr_q <= mptr_q + 15'h0001;
                end
              end
              else if (cptr_q == CR_MEMCTL)
              begin
                snl_q <= snl_q | b[SNL_POS];
                bp_q <= b[BP_LSB+:2];
                cptr_q <= cptr_q + 8'h01;
              end
              else if (cptr_q <= CR_SER_LAST && !snl_q)
              begin
                ser_q[3'(cptr_q - 8'h01)] <= b;
                cptr_q <= cptr_q + 8'h01;
              end
              else if (cptr_q != CR_CMD)
              begin
                ack_q <= 1'b0;
              end
            end
          endcase
        end
      end
      else if (scl_fall && bit_q == BIT_ACK)
      begin
        // Acknowledge slot or master's slot after a read byte
        sda_oe_n_q <= (st_q == S_RDATA) || !ack_q;
      end
      else if (scl_fall && load_q)
      begin
        load_q <= 1'b0;
        sda_oe_n_q <= 1'b1;
        if (st_q == S_RDATA)
        begin
          if (sel_mem_q)
          begin
            tx_q <= mem_q[mptr_q];
            sda_oe_n_q <= mem_q[mptr_q][7];
            mptr_q <= mptr_q + 15'h0001;
          end
          else
          begin
            tx_q <= creg;
            sda_oe_n_q <= creg[7];
            cptr_q <= (ca == CR_LAST) ? CR_MEMCTL : ca + 8'h01;
          end
        end
      end
      else if (scl_fall && st_q == S_RDATA && bit_q != 4'h0)
      begin
        tx_q <= {tx_q[6:0], 1'b0};
        sda_oe_n_q <= tx_q[6];
      end
      else if (scl_fall)
      begin
        sda_oe_n_q <= 1'b1;
      end
    end
  end

  // Working array: restore copy or link writes
  always_ff @(posedge sys_clk)
  begin
    if (pst_q == P_RESTORE && !cpd_q)
    begin
      mem_q[cp_q] <= nv_q[cp_q];
    end
    else if (mw_q)
    begin
      mem_q[mwa_q] <= mwd_q;
    end
  end

  // Nonvolatile copy taken during a save
  always_ff @(posedge sys_clk)
  begin
    if (pst_q == P_SAVE && !cpd_q)
    begin
      nv_q[cp_q] <= mem_q[cp_q];
    end
  end

  // Save, restore and lockout sequencer
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pst_q <= P_OFF;
      tim_q <= 32'h0;
      cp_q <= 15'h0000;
      cpd_q <= 1'b0;
      pl_q <= 1'b0;
      dirty_q <= 1'b0;
    end
    else
    begin
      tim_q <= tim_q + 32'h1;
      if (pst_q == P_SAVE || pst_q == P_RESTORE)
      begin
        cp_q <= cp_q + 15'h0001;
        cpd_q <= cpd_q || cp_q == MEM_LAST;
      end
      else
      begin
        cp_q <= 15'h0000;
        cpd_q <= 1'b0;
      end
      if (!sup_s && pst_q != P_OFF && pst_q != P_SAVE && pst_q != P_RESTORE)
      begin
        pst_q <= dirty_q ? P_SAVE : P_OFF;
        pl_q <= dirty_q;
        tim_q <= 32'h0;
      end
      else
      begin
        case (pst_q)
          P_OFF:
          begin
            pl_q <= 1'b0;
            tim_q <= 32'h0;
            if (sup_s)
            begin
              pst_q <= P_RESTORE;
            end
          end
          P_RESTORE:
          begin
            if (tim_q >= 32'(RESTORE_TIME - 1) && cpd_q)
            begin
              pst_q <= P_LOCK;
              tim_q <= 32'h0;
            end
          end
          P_READY:
          begin
            tim_q <= 32'h0;
            if (!stb_s)
            begin
              pst_q <= P_REQ;
            end
          end
          P_REQ:
          begin
            if (tim_q >= 32'(SAVE_REQ_DELAY - 1))
            begin
              pst_q <= dirty_q ? P_SAVE : P_LOCK;
              tim_q <= 32'h0;
            end
          end
          P_SAVE:
          begin
            if (tim_q >= 32'(SAVE_DURATION - 1) && cpd_q)
            begin
              pst_q <= pl_q ? P_OFF : P_RELEASE;
              tim_q <= 32'h0;
            end
          end
          P_RELEASE:
          begin
            if (tim_q >= 32'(RELEASE_DRIVE - 1))
            begin
              pst_q <= P_LOCK;
              tim_q <= 32'h0;
            end
          end
          default:
          begin
            // Lockout counts only once the pin reads high
            if (!stb_s)
            begin
              tim_q <= 32'h0;
            end
            else if (tim_q >= 32'(POST_LOCKOUT - 1))
            begin
              pst_q <= P_READY;
            end
          end
        endcase
      end
      // A link write in the same cycle as a clear keeps the flag set
      if (mw_q)
      begin
        dirty_q <= 1'b1;
      end
      else if ((pst_q == P_SAVE && tim_q >= 32'(SAVE_DURATION - 1) && cpd_q) ||
        (pst_q == P_RESTORE && tim_q >= 32'(RESTORE_TIME - 1) && cpd_q))
      begin
        dirty_q <= 1'b0;
      end
    end
  end

  // Store pin driver and status outputs
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_o_q <= 1'b0;
      st_oe_n_q <= 1'b1;
      mem_ready_q <= 1'b0;
      save_busy_q <= 1'b0;
    end
    else
    begin
      st_oe_n_q <= !(pst_q == P_SAVE || pst_q == P_RESTORE || pst_q == P_RELEASE);
      st_o_q <= pst_q == P_RELEASE;
      mem_ready_q <= pst_q == P_READY;
      save_busy_q <= pst_q == P_SAVE;
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = sda_oe_n_q;
  assign bus.dev_st_o = st_o_q;
  assign bus.dev_st_oe_n = st_oe_n_q;
endmodule

// ### bench/snv_props.sv
// Link checker for the serial nonvolatile SRAM ends
`timescale 1ns/1ps
module snv_props
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link signals
  input wire logic scl,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic host_st_oe_n,
  input wire logic dev_st_o,
  input wire logic dev_st_oe_n,
  input wire logic store_busy_pin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Wire and store pin relations
  a_sda_pull_only: assert property (dev_sda_o == 1'b0)
    else $error("device drives data high");
  a_sda_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device data changed with clock high");
  a_sda_hold_high: assert property (scl && !dev_sda_oe_n |=> !dev_sda_oe_n || !scl)
    else $error("device data released with clock high");
  a_pin_low_busy: assert property (!dev_st_oe_n && !dev_st_o |-> !store_busy_pin)
    else $error("store pin not low while busy");
  a_high_driven: assert property (dev_st_o |-> !dev_st_oe_n)
    else $error("store pin high level not driven");
  a_release_short: assert property ($rose(dev_st_o) |-> ##[1:4] !dev_st_o)
    else $error("store pin high drive too long");
  a_host_req_len: assert property ($fell(host_st_oe_n) |-> !host_st_oe_n[*6] ##[1:4] host_st_oe_n)
    else $error("save request length wrong");
  a_scl_low_min: assert property ($fell(scl) |-> !scl[*6])
    else $error("link clock low too short");
  // Main scenarios
  cover property ($fell(dev_sda_oe_n));
  cover property ($rose(dev_st_o));
  cover property ($fell(host_st_oe_n));
endmodule

// ### bench/serial_nvram_access_control_tb.sv
// Testbench joining host and device ends of the link
`timescale 1ns/1ps
module serial_nvram_access_control_tb;
  import snv_pkg::*;
  logic sys_clk = 0, reset_n = 0, supply_ok = 1, write_inhibit = 0;
  logic cmd_valid = 0, cmd_rd = 0, cmd_wr_en = 0, save_req = 0;
  logic [6:0] cmd_dev = 0;
  logic [1:0] cmd_naddr = 0;
  logic [15:0] cmd_addr = 0;
  logic [7:0] cmd_wdata = 0, rd_data_q;
  logic busy_q, done_q, nack_q, mem_ready_q, save_busy_q;
  int n_fail = 0, tests_run = 0, cyc = 0;
  snv_if snv_if_inst();
  snv_host snv_host_inst (.sys_clk(sys_clk), .reset_n(reset_n), .bus(snv_if_inst),
    .cmd_valid(cmd_valid), .cmd_dev(cmd_dev), .cmd_rd(cmd_rd), .cmd_naddr(cmd_naddr),
    .cmd_addr(cmd_addr), .cmd_wr_en(cmd_wr_en), .cmd_wdata(cmd_wdata), .save_req(save_req),
    .busy_q(busy_q), .done_q(done_q), .nack_q(nack_q), .rd_data_q(rd_data_q));
  snv_dev #(.SAVE_REQ_DELAY(4), .SAVE_DURATION(1), .RELEASE_DRIVE(2), .POST_LOCKOUT(4),
    .RESTORE_TIME(1)) snv_dev_inst (.sys_clk(sys_clk), .reset_n(reset_n), .bus(snv_if_inst),
    .supply_ok(supply_ok), .write_inhibit(write_inhibit), .mem_ready_q(mem_ready_q),
    .save_busy_q(save_busy_q));
  snv_props snv_props_inst (.sys_clk(sys_clk), .reset_n(reset_n), .scl(snv_if_inst.scl),
    .dev_sda_o(snv_if_inst.dev_sda_o), .dev_sda_oe_n(snv_if_inst.dev_sda_oe_n),
    .host_st_oe_n(snv_if_inst.host_st_oe_n), .dev_st_o(snv_if_inst.dev_st_o),
    .dev_st_oe_n(snv_if_inst.dev_st_oe_n), .store_busy_pin(snv_if_inst.store_busy_pin));
  // Clock
  initial forever #4 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask
  // One transfer, then judge acknowledge and read byte
  task automatic xf(input logic [6:0] d, input logic r, input logic [1:0] na,
    input logic [15:0] a, input logic w, input logic [7:0] wd, input logic en,
    input logic [7:0] ed);
    @(negedge sys_clk);
    {cmd_dev, cmd_rd, cmd_naddr, cmd_addr, cmd_wr_en, cmd_wdata} = {d, r, na, a, w, wd};
    cmd_valid = 1;
    @(negedge sys_clk);
    cmd_valid = 0;
    while (done_q !== 1'b1) @(negedge sys_clk);
    chk("nack", {15'h0, nack_q}, {15'h0, en});
    if (r) chk("read", {8'h0, rd_data_q}, {8'h0, ed});
  endtask
  task automatic s_refuse;
    xf(MEM_DEV_ID, 0, 2, 16'h1234, 1, 8'ha5, 0, 0);
    xf(7'h33, 0, 2, 16'h1234, 1, 8'h00, 1, 0);
    xf(MEM_DEV_ID, 0, 2, 16'h1234, 0, 0, 0, 0);
    xf(MEM_DEV_ID, 0, 2, 16'h8000, 0, 0, 1, 0);
    xf(MEM_DEV_ID, 1, 0, 0, 0, 0, 0, 8'ha5);
    write_inhibit = 1;
    xf(MEM_DEV_ID, 0, 2, 16'h1234, 1, 8'h5a, 1, 0);
    write_inhibit = 0;
    xf(MEM_DEV_ID, 1, 0, 0, 0, 0, 0, 8'ha5);
  endtask
  task automatic s_protect;
    xf(CTL_DEV_ID, 0, 1, 16'h0000, 1, 8'h0c, 0, 0);
    xf(MEM_DEV_ID, 0, 2, 16'h0010, 1, 8'h11, 1, 0);
    xf(CTL_DEV_ID, 0, 1, 16'h0000, 1, 8'h00, 0, 0);
  endtask
  // Supply loss with nothing written since the save: no save, memory off
  task automatic s_power_loss;
    supply_ok = 0;
    repeat (10) @(negedge sys_clk);
    chk("ready", {15'h0, mem_ready_q}, 0);
    chk("save busy", {15'h0, save_busy_q}, 0);
    chk("store pin", {15'h0, snv_if_inst.store_busy_pin}, 1);
  endtask
  task automatic s_save;
    @(negedge sys_clk);
    save_req = 1;
    @(negedge sys_clk);
    save_req = 0;
    repeat (50) @(negedge sys_clk);
    chk("store pin", {15'h0, snv_if_inst.store_busy_pin}, 0);
    chk("save busy", {15'h0, save_busy_q}, 1);
    chk("ready", {15'h0, mem_ready_q}, 0);
    while (mem_ready_q !== 1'b1) @(negedge sys_clk);
    chk("store pin", {15'h0, snv_if_inst.store_busy_pin}, 1);
    xf(MEM_DEV_ID, 0, 2, 16'h1234, 0, 0, 0, 0);
    xf(MEM_DEV_ID, 1, 0, 0, 0, 0, 0, 8'ha5);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence after restore
  initial
  begin
    repeat (2) @(negedge sys_clk);
    reset_n = 1;
    while (mem_ready_q !== 1'b1) @(negedge sys_clk);
    s_refuse();
    s_protect();
    s_save();
    s_power_loss();
    tally_and_finish();
  end
endmodule
